// *** include/lbp_pkg.sv ***
// Constants and carrier types for the local bus packet target block.
// Assumes the importing module runs a local clock domain and a link clock domain.
package lbp_pkg;
    // Bit positions of the fields in the first header word.
    localparam int TC_LSB = 29;
    localparam int SNOOP_BIT = 28;
    localparam int TYPE_LSB = 24;
    localparam int LBE_LSB = 20;
    localparam int FBE_LSB = 16;
    localparam int STAT_LSB = 16;
    localparam int LAST_BIT = 15;
    localparam int VC_BIT = 12;
    localparam int TAG_LSB = 10;
    localparam int LEN_LSB = 0;

    // Header type codes.
    localparam logic [3:0] TYPE_RD32 = 4'h0;
    localparam logic [3:0] TYPE_RD64 = 4'h1;
    localparam logic [3:0] TYPE_WR32 = 4'h2;
    localparam logic [3:0] TYPE_WR64 = 4'h3;
    localparam logic [3:0] TYPE_CPL = 4'h4;
    localparam logic [3:0] TYPE_CPLD = 4'h5;

    // Completion status codes.
    localparam logic [1:0] STAT_OK = 2'h0;
    localparam logic [1:0] STAT_UNSUPPORTED = 2'h1;
    localparam logic [1:0] STAT_ABORT = 2'h2;
    localparam logic [1:0] STAT_TIMEOUT = 2'h3;

    // Base address window hit codes.
    localparam logic [1:0] BAR_0 = 2'h0;
    localparam logic [1:0] BAR_2 = 2'h1;
    localparam logic [1:0] BAR_ROM = 2'h2;
    localparam logic [1:0] BAR_RSVD = 2'h3;

    // Window sizes in address bits.
    localparam int BAR0_WIN_BITS = 20;
    localparam int BAR2_WIN_BITS = 20;
    localparam int ROM_WIN_BITS = 16;

    // Counts and reset values.
    localparam logic [1:0] WR_RDY_MIN_CLKS = 2'h2;
    localparam logic [1:0] RD_DEPTH_ONE = 2'h1;
    localparam logic [1:0] RD_DEPTH_MAX = 2'h3;
    localparam int MAX_WORDS = 1024;
    localparam logic [10:0] MAX_WORDS_W = 11'h400;
    localparam logic [1:0] TAG_RESET = 2'h0;

    // Request taken from the PCIe side.
    typedef struct packed {
        logic [3:0] kind;
        logic [63:0] addr;
        logic [1:0] bar;
        logic [2:0] tc;
        logic no_snoop;
        logic vc;
        logic [3:0] fbe;
        logic [3:0] last_word_byte_lanes;
        logic [9:0] len;
    } lbp_req_t;

    // Packet handed to the link domain.
    typedef struct packed {
        logic [31:0] hdr;
        logic [31:0] addr;
        logic has_data;
        logic [10:0] words;
    } lbp_desc_t;

    // Completion header handed to the PCIe side.
    typedef struct packed {
        logic [2:0] tc;
        logic with_data;
        logic [1:0] stat;
        logic last;
        logic vc;
        logic [1:0] tag;
        logic [9:0] len;
    } lbp_cpl_t;
endpackage : lbp_pkg

// *** rtl/lbp_target_xfer.sv ***
// Target write and read packet engine of the bridge toward the local bus.
// Assumes the link clock clocks the inbound and outbound bus words of the attached logic.
// What this block does
// - Header type: 0 rd32, 1 rd64, 2 wr32, 3 wr64, 4 cpl, 5 cpl with data.
// - Completion status: 0 ok, 1 unsupported, 2 abort, 3 time-out.
// - Active high byte lanes for first and last word; single word uses first only.
// - Channel bit 0 or 1; single-lane parts always see 0.
// - Two-bit tag pairs reads and completions; bridge creates it for target reads.
// - Last bit set only on the final piece of a split completion.
// - Traffic class passes through unchanged.
// - Length counts words; zero means 1024 words.
// - Addresses are word aligned; low two address bits carry no meaning.
// - Window hit field: 0 first window, 1 second window, 2 boot ROM.
// - No-snoop bit copied from PCIe request into local request header; completion headers drop it.
// - Write packet: header, address, then data words.
// - After write ready rises, it passes two sync flops and must stay high two local clocks before the frame can start.
// - Request may rise without commitment and may drop when the transfer starts.
// - Frame may start once ready has been high two local clocks.
// - Ready drop leaves started transfers alone; raised ready means room for a full packet.
// - Only the address bits inside the decoded window are passed.
// - Only reads inside the two memory windows are forwarded.
// - One outstanding read per channel, three when the depth bit is set.
// - Read is a request packet then a completion packet; requests go back to back.
// - Writes are posted and get no completion.
// - Payloads are whole aligned words; partial words use byte lanes.
// - Frame high from the first word, low during the final word.
module lbp_target_xfer
    import lbp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_req_valid,
    input wire lbp_req_t i_req,
    output logic o_req_ready,
    output logic o_req_reject,
    input wire logic i_wdata_valid,
    input wire logic [31:0] i_wdata,
    output logic o_wdata_ready,
    input wire logic i_target_read_depth_vc0,
    input wire logic i_target_read_depth_vc1,
    input wire logic [1:0] i_write_ready,
    output logic [1:0] o_write_req,
    output logic [1:0] o_read_data_ready,
    output lbp_cpl_t o_cpl,
    output logic o_cpl_valid,
    output logic [31:0] o_cpl_word,
    output logic o_cpl_word_valid,
    output logic o_bad_header,
    output logic [15:0] o_inbound_bus_word,
    output logic o_inbound_packet_frame,
    input wire logic [15:0] i_outbound_bus_word,
    input wire logic i_outbound_packet_frame
);
    typedef enum logic [2:0] {L_IDLE, L_LOAD, L_HOLD, L_WREQ, L_SEND} lbp_lstate_t;
    typedef enum logic [0:0] {C_IDLE, C_DATA} lbp_cstate_t;
    typedef enum logic [0:0] {T_IDLE, T_SEND} lbp_tstate_t;
    typedef enum logic [1:0] {R_IDLE, R_RECV, R_HELD} lbp_rstate_t;

    // Words counted by a length field, zero standing for the maximum.
    function automatic logic [10:0] words_of(input logic [9:0] len);
        return (len == 10'h000) ? MAX_WORDS_W : {1'b0, len};
    endfunction : words_of

    // A request is forwarded only with a request type and a usable window.
    function automatic logic req_ok(input lbp_req_t r);
        logic bad_type;
        logic bad_bar;
        bad_type = r.kind > TYPE_WR64;
        bad_bar = (r.bar == BAR_RSVD) || (!r.kind[1] && r.bar == BAR_ROM);
        return !bad_type && !bad_bar;
    endfunction : req_ok

    // Address word keeps the in-window bits and carries the hit code low.
    function automatic logic [31:0] win_addr(input logic [63:0] a, input logic [1:0] bar);
        logic [31:0] m;
        m = 32'h0000_0000;
        case (bar)
            BAR_0: m = (32'h0000_0001 << BAR0_WIN_BITS) - 32'h0000_0001;
            BAR_2: m = (32'h0000_0001 << BAR2_WIN_BITS) - 32'h0000_0001;
            BAR_ROM: m = (32'h0000_0001 << ROM_WIN_BITS) - 32'h0000_0001;
            default: m = 32'h0000_0000;
        endcase
        return {a[31:2] & m[31:2], bar};
    endfunction : win_addr

    // First header word of an inbound request; unused bits stay zero.
    function automatic logic [31:0] req_hdr(input lbp_req_t r, input logic [1:0] t);
        logic [31:0] h;
        h = 32'h0000_0000;
        h[TC_LSB +: 3] = r.tc;
        h[SNOOP_BIT] = r.no_snoop;
        h[TYPE_LSB +: 4] = r.kind[1] ? TYPE_WR32 : TYPE_RD32;
        h[LBE_LSB +: 4] = (r.len == 10'h001) ? 4'h0 : r.last_word_byte_lanes;
        h[FBE_LSB +: 4] = r.fbe;
        h[VC_BIT] = r.vc;
        if (!r.kind[1]) begin
            h[TAG_LSB +: 2] = t;
        end
        h[LEN_LSB +: 10] = r.len;
        return h;
    endfunction : req_hdr

    lbp_lstate_t lstate;
    lbp_cstate_t cstate;
    lbp_tstate_t tstate;
    lbp_rstate_t rstate;
    lbp_desc_t desc;
    logic [31:0] wbuf [0:MAX_WORDS-1];
    logic [31:0] cbuf [0:MAX_WORDS-1];
    logic [10:0] load_idx, c_idx, c_cnt, rx_idx, cpl_cnt;
    logic [1:0] tag, wr_rdy_s1, wr_rdy_s2, rd_issue, rd_free;
    logic [1:0][1:0] rd_out, rdy_age;
    logic req_vc, tx_tgl, ack_s1, ack_s2, cs1, cs2, rel_tgl, busy_s1, busy_s2;
    logic link_rst_s1, link_rst, ts1, ts2, tx_ack, t_half, rs1, rs2, ob_frame;
    logic r_half, r_first, frame_w, cpl_bad, cpl_tgl, rx_busy;
    logic [11:0] w_idx, tx_total;
    logic [15:0] ob_word, lo_half;
    logic [31:0] cpl_hdr, rx_word, hdr_now, cur_word;
    logic req_take, wd_take, wd_last, rd_room, wr_go, rx_store, tx_last;

    // Handshake terms of the local side.
    assign req_take = i_req_valid && o_req_ready;
    assign wd_take = i_wdata_valid && o_wdata_ready;
    assign wd_last = load_idx == (desc.words - 11'h001);
    assign rd_room = rd_out[req_vc] < ((req_vc ? i_target_read_depth_vc1 : i_target_read_depth_vc0)
                     ? RD_DEPTH_MAX : RD_DEPTH_ONE);
    assign wr_go = wr_rdy_s2[req_vc] && (rdy_age[req_vc] >= WR_RDY_MIN_CLKS);
    assign rd_issue = {2{lstate == L_HOLD && rd_room}} & {req_vc, !req_vc};
    assign rd_free = {2{o_cpl_valid && o_cpl.last}} & {o_cpl.vc, !o_cpl.vc};

    // Main request sequencer of the local domain.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            lstate <= L_IDLE;
            desc <= '0;
            load_idx <= 11'h000;
            req_vc <= 1'b0;
            tx_tgl <= 1'b0;
            o_req_reject <= 1'b0;
        end else begin
            o_req_reject <= 1'b0;
            case (lstate)
                L_IDLE: begin
                    if (req_take && !req_ok(i_req)) begin
                        o_req_reject <= 1'b1;
                    end else if (req_take) begin
                        desc.hdr <= req_hdr(i_req, tag);
                        desc.addr <= win_addr(i_req.addr, i_req.bar);
                        desc.has_data <= i_req.kind[1];
                        desc.words <= words_of(i_req.len);
                        req_vc <= i_req.vc;
                        load_idx <= 11'h000;
                        lstate <= i_req.kind[1] ? L_LOAD : L_HOLD;
                    end
                end
                L_LOAD: begin
                    if (wd_take) begin
                        load_idx <= load_idx + 11'h001;
                        if (wd_last) begin
                            lstate <= L_WREQ;
                        end
                    end
                end
                L_HOLD: begin
                    if (rd_room) begin
                        tx_tgl <= ~tx_tgl;
                        lstate <= L_SEND;
                    end
                end
                L_WREQ: begin
                    if (wr_go) begin
                        tx_tgl <= ~tx_tgl;
                        lstate <= L_SEND;
                    end
                end
                L_SEND: begin
                    if (ack_s2 == tx_tgl) begin
                        lstate <= L_IDLE;
                    end
                end
                default: lstate <= L_IDLE;
            endcase
        end
    end

    // Ready flags toward the PCIe side and the write request pins.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_req_ready <= 1'b0;
            o_wdata_ready <= 1'b0;
            o_write_req <= 2'b00;
        end else begin
            o_req_ready <= (lstate == L_IDLE) && !req_take;
            o_wdata_ready <= (lstate == L_LOAD) && !(wd_take && wd_last);
            o_write_req <= 2'b00;
            if (lstate == L_WREQ && !wr_go) begin
                o_write_req[req_vc] <= 1'b1;
            end
        end
    end

    // Write payload store, read later by the link side.
    always_ff @(posedge i_clk) begin
        if (wd_take) begin
            wbuf[load_idx[9:0]] <= i_wdata;
        end
    end

    // Write ready pins pass two flops, then their high time is counted.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_rdy_s1 <= 2'b00;
            wr_rdy_s2 <= 2'b00;
            rdy_age <= '0;
        end else begin
            wr_rdy_s1 <= i_write_ready;
            wr_rdy_s2 <= wr_rdy_s1;
            for (int v = 0; v < 2; v++) begin
                if (!wr_rdy_s2[v]) begin
                    rdy_age[v] <= 2'h0;
                end else if (rdy_age[v] != 2'h3) begin
                    rdy_age[v] <= rdy_age[v] + 2'h1;
                end
            end
        end
    end

    // Outstanding reads per channel; a final completion frees one.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_out <= '0;
            tag <= TAG_RESET;
        end else begin
            if (lstate == L_HOLD && rd_room) begin
                tag <= tag + 2'h1;
            end
            for (int v = 0; v < 2; v++) begin
                if (rd_issue[v] && !rd_free[v]) begin
                    rd_out[v] <= rd_out[v] + 2'h1;
                end else if (rd_free[v] && !rd_issue[v] && rd_out[v] != 2'h0) begin
                    rd_out[v] <= rd_out[v] - 2'h1;
                end
            end
        end
    end

    // Crossings into the local domain.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {ack_s1, ack_s2, cs1, cs2, busy_s1, busy_s2} <= 6'h00;
            o_read_data_ready <= 2'b00;
        end else begin
            ack_s1 <= tx_ack;
            ack_s2 <= ack_s1;
            cs1 <= cpl_tgl;
            cs2 <= cs1;
            busy_s1 <= rx_busy;
            busy_s2 <= busy_s1;
            o_read_data_ready <= {2{!busy_s2}};
        end
    end

    // Completion delivery from the held link buffer to the PCIe side.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cstate <= C_IDLE;
            rel_tgl <= 1'b0;
            c_idx <= 11'h000;
            c_cnt <= 11'h000;
            o_cpl <= '0;
            o_cpl_valid <= 1'b0;
            o_cpl_word <= 32'h0000_0000;
            o_cpl_word_valid <= 1'b0;
            o_bad_header <= 1'b0;
        end else begin
            o_cpl_valid <= 1'b0;
            o_cpl_word_valid <= 1'b0;
            o_bad_header <= 1'b0;
            case (cstate)
                C_IDLE: begin
                    if (cs2 != rel_tgl && cpl_bad) begin
                        o_bad_header <= 1'b1;
                        rel_tgl <= ~rel_tgl;
                    end else if (cs2 != rel_tgl) begin
                        o_cpl.tc <= cpl_hdr[TC_LSB +: 3];
                        o_cpl.with_data <= cpl_hdr[TYPE_LSB +: 4] == TYPE_CPLD;
                        o_cpl.stat <= cpl_hdr[STAT_LSB +: 2];
                        o_cpl.last <= cpl_hdr[LAST_BIT];
                        o_cpl.vc <= cpl_hdr[VC_BIT];
                        o_cpl.tag <= cpl_hdr[TAG_LSB +: 2];
                        o_cpl.len <= cpl_hdr[LEN_LSB +: 10];
                        o_cpl_valid <= 1'b1;
                        c_idx <= 11'h000;
                        c_cnt <= cpl_cnt;
                        if (cpl_cnt == 11'h000) begin
                            rel_tgl <= ~rel_tgl;
                        end else begin
                            cstate <= C_DATA;
                        end
                    end
                end
                C_DATA: begin
                    o_cpl_word <= cbuf[c_idx[9:0]];
                    o_cpl_word_valid <= 1'b1;
                    c_idx <= c_idx + 11'h001;
                    if (c_idx == c_cnt - 11'h001) begin
                        rel_tgl <= ~rel_tgl;
                        cstate <= C_IDLE;
                    end
                end
                default: cstate <= C_IDLE;
            endcase
        end
    end

    // Link domain reset: asserted at once, released on the link clock.
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            link_rst_s1 <= 1'b1;
            link_rst <= 1'b1;
        end else begin
            link_rst_s1 <= 1'b0;
            link_rst <= link_rst_s1;
        end
    end

    // Crossings into the link domain and the outbound pin register.
    always_ff @(posedge i_link_clk or posedge link_rst) begin
        if (link_rst) begin
            {ts1, ts2, rs1, rs2, ob_frame} <= 5'h00;
            ob_word <= 16'h0000;
        end else begin
            ts1 <= tx_tgl;
            ts2 <= ts1;
            rs1 <= rel_tgl;
            rs2 <= rs1;
            ob_word <= i_outbound_bus_word;
            ob_frame <= i_outbound_packet_frame;
        end
    end

    // Word being sent: header, address, then payload.
    assign cur_word = (w_idx == 12'h000) ? desc.hdr : (w_idx == 12'h001) ? desc.addr
                      : wbuf[w_idx[9:0] - 10'h002];
    assign tx_total = desc.has_data ? ({1'b0, desc.words} + 12'h002) : 12'h002;
    assign tx_last = w_idx == (tx_total - 12'h001);

    // Inbound serializer: each word goes out as low half, then high half.
    always_ff @(posedge i_link_clk or posedge link_rst) begin
        if (link_rst) begin
            tstate <= T_IDLE;
            tx_ack <= 1'b0;
            w_idx <= 12'h000;
            t_half <= 1'b0;
            o_inbound_bus_word <= 16'h0000;
            o_inbound_packet_frame <= 1'b0;
        end else begin
            case (tstate)
                T_IDLE: begin
                    o_inbound_bus_word <= 16'h0000;
                    o_inbound_packet_frame <= 1'b0;
                    w_idx <= 12'h000;
                    t_half <= 1'b0;
                    if (ts2 != tx_ack) begin
                        tstate <= T_SEND;
                    end
                end
                T_SEND: begin
                    o_inbound_bus_word <= t_half ? cur_word[31:16] : cur_word[15:0];
                    o_inbound_packet_frame <= !tx_last;
                    t_half <= ~t_half;
                    if (t_half && tx_last) begin
                        tx_ack <= ~tx_ack;
                        tstate <= T_IDLE;
                    end else if (t_half) begin
                        w_idx <= w_idx + 12'h001;
                    end
                end
                default: tstate <= T_IDLE;
            endcase
        end
    end

    // Assembly of an outbound word and whether it is payload to keep.
    assign rx_word = {ob_word, lo_half};
    assign hdr_now = r_first ? rx_word : cpl_hdr;
    assign rx_store = r_half && !r_first && (cpl_hdr[TYPE_LSB +: 4] == TYPE_CPLD) && (rx_idx < MAX_WORDS_W);

    // Outbound completion receiver, held until the local side releases it.
    always_ff @(posedge i_link_clk or posedge link_rst) begin
        if (link_rst) begin
            rstate <= R_IDLE;
            {lo_half, rx_idx, cpl_cnt, cpl_hdr} <= '0;
            {r_half, r_first, frame_w, cpl_bad, cpl_tgl, rx_busy} <= 6'h00;
        end else begin
            case (rstate)
                R_IDLE: begin
                    if (ob_frame) begin
                        lo_half <= ob_word;
                        frame_w <= 1'b1;
                        r_half <= 1'b1;
                        r_first <= 1'b1;
                        rx_idx <= 11'h000;
                        rx_busy <= 1'b1;
                        rstate <= R_RECV;
                    end
                end
                R_RECV: begin
                    r_half <= ~r_half;
                    if (!r_half) begin
                        lo_half <= ob_word;
                        frame_w <= ob_frame;
                    end else begin
                        r_first <= 1'b0;
                        if (r_first) begin
                            cpl_hdr <= rx_word & {3'h7, 1'b0, 4'hF, 6'h00, 2'h3, 1'b1, 2'h0, 13'h1FFF};
                        end
                        if (rx_store) begin
                            rx_idx <= rx_idx + 11'h001;
                        end
                        if (!frame_w) begin
                            cpl_cnt <= rx_store ? (rx_idx + 11'h001) : rx_idx;
                            cpl_bad <= (hdr_now[TYPE_LSB +: 4] != TYPE_CPL)
                                       && (hdr_now[TYPE_LSB +: 4] != TYPE_CPLD);
                            cpl_tgl <= ~cpl_tgl;
                            rstate <= R_HELD;
                        end
                    end
                end
                R_HELD: begin
                    if (rs2 == cpl_tgl) begin
                        rx_busy <= 1'b0;
                        rstate <= R_IDLE;
                    end
                end
                default: rstate <= R_IDLE;
            endcase
        end
    end

    // Completion payload store, read later by the local side.
    always_ff @(posedge i_link_clk) begin
        if (rstate == R_RECV && rx_store) begin
            cbuf[rx_idx[9:0]] <= rx_word;
        end
    end
endmodule : lbp_target_xfer

// *** dv/lbp_target_xfer_assertions.sv ***
// Port checker for the target packet engine.
// Assumes it is bound to lbp_target_xfer and that both clocks run.
module lbp_target_xfer_assertions (
    input wire logic i_clk, i_rst, i_link_clk, i_req_valid, o_req_ready, o_req_reject, o_wdata_ready,
    input wire logic o_cpl_valid, o_inbound_packet_frame,
    input wire logic [1:0] i_write_ready, o_write_req, o_read_data_ready
);
    // Frame opens over two high halves, closes over two low halves; a request waits on ready.
    sequence open_s; o_inbound_packet_frame ##1 o_inbound_packet_frame; endsequence
    sequence close_s; !o_inbound_packet_frame ##1 !o_inbound_packet_frame; endsequence
    sequence wait_s; o_write_req[0] && !i_write_ready[0] ##1 !i_write_ready[0]; endsequence
    a_frame_open: assert property (@(posedge i_link_clk) disable iff (i_rst) $rose(o_inbound_packet_frame) |-> open_s)
        else $error("frame open short");
    a_frame_close: assert property (@(posedge i_link_clk) disable iff (i_rst) $fell(o_inbound_packet_frame) |-> close_s)
        else $error("frame close short");
    a_write_hold: assert property (@(posedge i_clk) disable iff (i_rst) wait_s |=> o_write_req[0])
        else $error("write request left early");
    a_take_busy: assert property (@(posedge i_clk) disable iff (i_rst) i_req_valid && o_req_ready |=> !o_req_ready)
        else $error("second request taken");
    a_reject_pulse: assert property (@(posedge i_clk) disable iff (i_rst) o_req_reject |=> !o_req_reject)
        else $error("reject too long");
    a_cpl_pulse: assert property (@(posedge i_clk) disable iff (i_rst) o_cpl_valid |=> !o_cpl_valid)
        else $error("completion too long");
    a_rdy_pair: assert property (@(posedge i_clk) disable iff (i_rst) o_read_data_ready[0] == o_read_data_ready[1])
        else $error("read ready split");
    a_data_order: assert property (@(posedge i_clk) disable iff (i_rst) o_wdata_ready |-> !o_req_ready)
        else $error("payload outside a write");
endmodule : lbp_target_xfer_assertions
bind lbp_target_xfer lbp_target_xfer_assertions u_chk (.i_clk, .i_rst, .i_link_clk, .i_req_valid, .o_req_ready,
    .o_req_reject, .o_wdata_ready, .o_cpl_valid, .o_inbound_packet_frame, .i_write_ready, .o_write_req,
    .o_read_data_ready);

// *** dv/lbp_fpga_model.sv ***
// Model of the FPGA logic at the link side of the target engine.
// Assumes one link clock for both directions; each read gets one data word.
module lbp_fpga_model
    import lbp_pkg::*;
#(parameter logic [31:0] CPL_DATA = 32'h0000_0000) (
    input wire logic i_clk, i_rst, i_fr, input wire logic [15:0] i_wd, input wire logic [1:0] i_req,
    output logic o_fr, output logic [15:0] o_wd, output logic [1:0] o_rdy,
    output logic [31:0] o_hdr, o_adr, o_dat, output logic [7:0] o_n
);
    logic [15:0] lo;
    logic hi, inp, frl, go;
    logic [1:0] wi;
    logic [2:0] si;
    logic [31:0] ch, tx;
    // Answer header echoes class, channel and tag of the request.
    assign ch = {o_hdr[31:29], 1'b0, TYPE_CPLD, 6'h00, STAT_OK, 1'b1, 2'h0, o_hdr[12:10], 10'h001};
    assign tx = (si < 3'h3) ? ch : CPL_DATA;
    // Rebuilds words, low half first, and ends a packet on a low-frame word.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            {hi, inp, frl, go, wi, o_n, lo, o_hdr, o_adr, o_dat, o_rdy} <= '0;
        end else begin
            o_rdy <= o_rdy | i_req;
            go <= 1'b0;
            if (inp || i_fr) begin
                hi <= !hi;
                inp <= hi ? frl : 1'b1;
                if (!hi) {lo, frl} <= {i_wd, i_fr};
                else begin
                    if (wi == 2'h0) o_hdr <= {i_wd, lo};
                    else if (wi == 2'h1) o_adr <= {i_wd, lo};
                    else o_dat <= {i_wd, lo};
                    wi <= frl ? wi + 2'h1 : 2'h0;
                    o_n <= o_n + {7'h00, !frl};
                    go <= !frl && wi == 2'h1 && o_hdr[27:24] == TYPE_RD32;
                end
            end
        end
    end
    // Sends the answer; between frames the data lines keep changing.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) {si, o_fr, o_wd} <= '0;
        else if (si != 3'h0) begin
            o_wd <= si[0] ? tx[15:0] : tx[31:16];
            o_fr <= si < 3'h3;
            si <= (si == 3'h4) ? 3'h0 : si + 3'h1;
        end else begin
            o_wd <= ~o_wd;
            o_fr <= 1'b0;
            si <= {2'h0, go};
        end
    end
endmodule : lbp_fpga_model

// *** dv/lbp_target_xfer_tb.sv ***
// Bench for the target packet engine: a write, a read and two refusals.
// Assumes the FPGA model answers each read with one data word.
module lbp_target_xfer_tb
    import lbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CPL_DATA = 32'hC0DE_5A5A;
    logic i_clk = 0, i_rst = 1, i_link_clk = 0, i_req_valid = 0, i_wdata_valid = 0;
    logic i_target_read_depth_vc0 = 0, i_target_read_depth_vc1 = 0, i_outbound_packet_frame, o_inbound_packet_frame;
    logic o_req_ready, o_req_reject, o_wdata_ready, o_cpl_valid, o_cpl_word_valid, o_bad_header;
    logic [1:0] i_write_ready, o_write_req, o_read_data_ready;
    logic [15:0] o_inbound_bus_word, i_outbound_bus_word;
    logic [31:0] i_wdata = 0, o_cpl_word, hdr, adr, dat;
    logic [7:0] pkts;
    lbp_req_t i_req = '0;
    lbp_cpl_t o_cpl;
    int errors = 0, check_count = 0, cpls = 0;
    lbp_target_xfer u_lbp_target_xfer (.*);
    lbp_fpga_model #(.CPL_DATA(CPL_DATA)) u_lbp_fpga_model (.i_clk(i_link_clk), .i_rst, .i_fr(o_inbound_packet_frame),
        .i_wd(o_inbound_bus_word), .i_req(o_write_req), .o_fr(i_outbound_packet_frame), .o_wd(i_outbound_bus_word),
        .o_rdy(i_write_ready), .o_hdr(hdr), .o_adr(adr), .o_dat(dat), .o_n(pkts));
    // Clocks, and a count of completions.
    initial forever #25 i_clk = ~i_clk;
    initial #3 forever #80 i_link_clk = ~i_link_clk;
    always @(posedge i_clk) if (o_cpl_valid === 1'b1) cpls++;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Holds one request until the engine is ready to take it.
    task automatic send(input logic [3:0] kind, input logic [1:0] bar, input logic vc);
        @(negedge i_clk);
        i_req = '{kind, 64'h0000_0009_1234_5678, bar, 3'h5, 1'b1, vc, 4'hF, 4'h0, 10'h001};
        i_req_valid = 1;
        while (o_req_ready !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        i_req_valid = 0;
    endtask : send
    task automatic write_test();
        send(TYPE_WR32, BAR_0, 1'b0);
        i_wdata = 32'hBEEF_0001;
        i_wdata_valid = 1;
        while (o_wdata_ready !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
        i_wdata_valid = 0;
        wait (pkts == 8'h01);
        check(hdr, {3'h5, 1'b1, TYPE_WR32, 4'h0, 4'hF, 16'h0001});
        check(adr, 32'h0004_5678);
        check(dat, 32'hBEEF_0001);
    endtask : write_test
    task automatic read_test();
        send(TYPE_RD32, BAR_2, 1'b1);
        wait (pkts == 8'h02);
        check(hdr, {3'h5, 1'b1, TYPE_RD32, 4'h0, 4'hF, 3'h0, 1'b1, TAG_RESET, 10'h001});
        check(adr, 32'h0004_5679);
        wait (o_cpl_word_valid === 1'b1);
        @(negedge i_clk);
        check(o_cpl_word, CPL_DATA);
        check(o_cpl, {3'h5, 1'b1, STAT_OK, 1'b1, 1'b1, TAG_RESET, 10'h001});
        check(cpls, 1);
    endtask : read_test
    task automatic reject_test();
        for (int k = 0; k < 2; k++) begin
            send(k ? 4'h7 : TYPE_RD32, k ? BAR_0 : BAR_ROM, 1'b0);
            repeat (4) if (o_req_reject !== 1'b1) @(negedge i_clk);
            check(o_req_reject, 1'b1);
        end
        repeat (60) @(negedge i_clk);
        check(pkts, 8'h02);
        check(o_read_data_ready, 2'b11);
    endtask : reject_test
    // Main sequence, and a watchdog sized well past the expected run.
    initial begin
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 0;
        write_test();
        read_test();
        reject_test();
        wrap_up();
    end
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule : lbp_target_xfer_tb
